// File: dsp_pkg.sv
// Shared constants and types for the debug scan processor-access block.
// Assumes a single system clock domain; the test clock is sampled.
package dsp_pkg;

  // Instruction register width and codes
  localparam int unsigned IR_W       = 5;
  localparam logic [4:0]  IR_BYPASS  = 5'h1F;
  localparam logic [4:0]  IR_IDCODE  = 5'h01;
  localparam logic [4:0]  IR_IMPL    = 5'h03;
  localparam logic [4:0]  IR_ADDR    = 5'h08;
  localparam logic [4:0]  IR_DATA    = 5'h09;
  localparam logic [4:0]  IR_CTRL    = 5'h0A;
  localparam logic [4:0]  IR_TRACE   = 5'h12;
  localparam logic [4:0]  IR_CAPTURE = 5'h01;

  // Probe memory window and debug vector
  localparam logic [31:0] WIN_LO     = 32'hFF200000;
  localparam logic [31:0] WIN_HI     = 32'hFF2FFFFF;
  localparam logic [31:0] VEC_ADDR   = 32'hFF200200;

  // Arbitrary identification value; bit 0 set as scan convention asks
  localparam logic [31:0] IDCODE_DEF = 32'h00000001;
  localparam logic [31:0] IMPL_DEF   = 32'h00000000;

  // Control scan register field positions
  localparam int unsigned CB_DM      = 3;
  localparam int unsigned CB_PEN     = 15;
  localparam int unsigned CB_DMA     = 17;
  localparam int unsigned CB_PACC    = 18;
  localparam int unsigned CB_DIR     = 19;
  localparam int unsigned CB_SZ      = 29;
  localparam logic [1:0]  SIZE_WORD  = 2'h2;

  // APB register map and fields
  localparam logic [11:0] ADDR_CFG   = 12'h000;
  localparam logic [11:0] ADDR_STAT  = 12'h004;
  localparam int unsigned CFG_BE     = 0;
  localparam int unsigned ST_PACC    = 0;
  localparam int unsigned ST_DIR     = 1;
  localparam int unsigned ST_PEN     = 2;
  localparam int unsigned ST_TRACE   = 3;
  localparam int unsigned ST_IR      = 8;
  localparam logic        CFG_BE_RST = 1'b0;

  typedef enum logic [3:0] {
    T_TLR = 4'h0, T_RTI = 4'h1, T_SELDR = 4'h2, T_CAPDR = 4'h3,
    T_SHDR = 4'h4, T_EX1DR = 4'h5, T_PAUDR = 4'h6, T_EX2DR = 4'h7,
    T_UPDR = 4'h8, T_SELIR = 4'h9, T_CAPIR = 4'hA, T_SHIR = 4'hB,
    T_EX1IR = 4'hC, T_PAUIR = 4'hD, T_EX2IR = 4'hE, T_UPIR = 4'hF
  } dsp_tap_type;

  typedef enum logic [1:0] {
    PS_IDLE = 2'h0, PS_WAIT = 2'h1, PS_DONE = 2'h2
  } dsp_pst_type;

  // Processor-side access request
  typedef struct packed {
    logic        we;
    logic [1:0]  size;
    logic [31:0] addr;
    logic [31:0] wdata;
  } dsp_preq_type;

endpackage : dsp_pkg

// File: dsp_sync2.sv
// Two-flop synchroniser for asynchronous levels.
// Assumes the destination clock is the system clock.
`timescale 1ns/1ps
module dsp_sync2 #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r;

  // First stage feeds only the second
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : dsp_sync2

// File: dsp_scan_reg.sv
// One scan shift stage chain with parallel capture, LSB toward output.
// Assumes capture and shift strobes are single-cycle test clock rises.
`timescale 1ns/1ps
module dsp_scan_reg #(
  parameter int W = 32
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         cap,
  input  wire logic         shf,
  input  wire logic [W-1:0] cap_val,
  input  wire logic         sdi,
  output logic      [W-1:0] q
);
  generate
    if (W == 1) begin : g_one
      // Single stage
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) q <= '0;
        else if (cap) q <= cap_val;
        else if (shf) q <= sdi;
      end
    end else begin : g_many
      // Shift toward bit 0
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) q <= '0;
        else if (cap) q <= cap_val;
        else if (shf) q <= {sdi, q[W-1:1]};
      end
    end
  endgenerate
endmodule : dsp_scan_reg

// File: dsp_debug_scan.sv
// Debug scan data registers with probe-memory access handshake.
// Assumes test pins are asynchronous to mclk and TCK is much slower.
`timescale 1ns/1ps
//
// Contract
// - Data registers sit in parallel; current instruction picks one.
// - Unselected scan paths hold their contents during capture and shift.
// - Bypass stage loads zero at capture when selected.
// - Bypass use leaves functional behaviour untouched.
// - Identification register shifts out under the identification code.
// - Read-only 32-bit implementation register reports built-in features.
// - 32-bit address register captures requested probe address.
// - Data register captures store data, delivers shifted read data.
// - Byte lanes in data register follow current endianness.
// - Control register selected by its instruction; writable and status bits.
// - Control register reachable only through the serial port.
// - Trace instruction plus run-test/idle starts trace with status bus.
// - Debug exception ends trace and forces bypass instruction.
// - Probe access needs window address, probe enable, and debug mode.
// - Debug exception with probe enable fetches from probe vector.
// - Read: latch address, set pending, direction read, size.
// - Probe clears pending; processor then consumes the shifted word.
// - Processor advances and requests each next instruction afresh.
// - Loads in the probe window use the fetch handshake.
// - Store: latch address and data, set pending, direction write, size.
// - Probe clears pending after store; processor may start again.
// - Scan logic steps on sampled test clock edges; scan and access logic both run on mclk.
// - Shift one stage per rise, drive output LSB first on fall.
module dsp_debug_scan #(
  parameter logic [31:0] IDCODE_VAL = dsp_pkg::IDCODE_DEF,
  parameter logic [31:0] IMPL_VAL   = dsp_pkg::IMPL_DEF
) (
  input  wire logic                  mclk,
  input  wire logic                  reset_n,
  input  wire logic                  tck,
  input  wire logic                  tms,
  input  wire logic                  tdi,
  output logic                       tdo,
  output logic                       tdo_oe_n,
  input  wire logic [11:0]           paddr,
  input  wire logic                  psel,
  input  wire logic                  penable,
  input  wire logic                  pwrite,
  input  wire logic [31:0]           pwdata,
  output logic      [31:0]           prdata,
  output logic                       pready,
  output logic                       pslverr,
  input  wire logic                  proc_req,
  input  wire dsp_pkg::dsp_preq_type proc_pkt,
  input  wire logic                  proc_debug_mode,
  output logic                       proc_stall,
  output logic                       proc_done,
  output logic                       proc_refused,
  output logic      [31:0]           proc_rdata,
  input  wire logic                  dbg_exc,
  input  wire logic [31:0]           trace_pc,
  input  wire logic                  trace_pc_valid,
  input  wire logic [2:0]            trace_type,
  output logic      [2:0]            pcst,
  output logic                       trace_active
);
  import dsp_pkg::*;

  logic        rst_a_r, rst_n;
  logic [2:0]  pin_s;
  logic        tck_d_r, tck_rise, tck_fall;
  dsp_tap_type tap_r, tap_nxt;
  dsp_pst_type pst_r;
  logic [4:0]  ir_r, ir_q;
  logic        sel_byp, sel_id, sel_imp, sel_adr, sel_dat, sel_ctl;
  logic        dr_cap, dr_shf, dr_upd, sel_q0;
  logic        byp_q;
  logic [31:0] id_q, imp_q, adr_q, dat_q, ctl_q, ctl_stat;
  logic [31:0] addr_hold_r, data_hold_r, trace_sr_r, prdata_r;
  logic [1:0]  size_r;
  logic        pend_r, dir_r, pen_r, dma_r, vec_r, be_r;
  logic        allowed, accept, ctl_clear;
  logic        tdo_r, tdo_oe_n_r, trace_r;
  logic [2:0]  pcst_r;

  // Byte reversal between bus lanes and scan order
  function automatic logic [31:0] lane_fix(input logic [31:0] w,
                                           input logic        be);
    lane_fix = be ? {w[7:0], w[15:8], w[23:16], w[31:24]} : w;
  endfunction : lane_fix

  // Reset release through two flops
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rst_a_r <= 1'b0;
      rst_n   <= 1'b0;
    end else begin
      rst_a_r <= 1'b1;
      rst_n   <= rst_a_r;
    end
  end

  // Test pins into the mclk domain
  dsp_sync2 #(.W(3)) u_pins (
    .clk   (mclk),
    .rst_n (rst_n),
    .d     ({tck, tms, tdi}),
    .q     (pin_s)
  );

  // Test clock edges found by sampling; scan logic steps on them
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tck_d_r <= 1'b0;
    else tck_d_r <= pin_s[2];
  end
  assign tck_rise = pin_s[2] & ~tck_d_r;
  assign tck_fall = ~pin_s[2] & tck_d_r;

  // Controller next state from TMS
  always_comb begin
    tap_nxt = tap_r;
    case (tap_r)
      T_TLR:   tap_nxt = pin_s[1] ? T_TLR   : T_RTI;
      T_RTI:   tap_nxt = pin_s[1] ? T_SELDR : T_RTI;
      T_SELDR: tap_nxt = pin_s[1] ? T_SELIR : T_CAPDR;
      T_CAPDR: tap_nxt = pin_s[1] ? T_EX1DR : T_SHDR;
      T_SHDR:  tap_nxt = pin_s[1] ? T_EX1DR : T_SHDR;
      T_EX1DR: tap_nxt = pin_s[1] ? T_UPDR  : T_PAUDR;
      T_PAUDR: tap_nxt = pin_s[1] ? T_EX2DR : T_PAUDR;
      T_EX2DR: tap_nxt = pin_s[1] ? T_UPDR  : T_SHDR;
      T_UPDR:  tap_nxt = pin_s[1] ? T_SELDR : T_RTI;
      T_SELIR: tap_nxt = pin_s[1] ? T_TLR   : T_CAPIR;
      T_CAPIR: tap_nxt = pin_s[1] ? T_EX1IR : T_SHIR;
      T_SHIR:  tap_nxt = pin_s[1] ? T_EX1IR : T_SHIR;
      T_EX1IR: tap_nxt = pin_s[1] ? T_UPIR  : T_PAUIR;
      T_PAUIR: tap_nxt = pin_s[1] ? T_EX2IR : T_PAUIR;
      T_EX2IR: tap_nxt = pin_s[1] ? T_UPIR  : T_SHIR;
      T_UPIR:  tap_nxt = pin_s[1] ? T_SELDR : T_RTI;
      default: tap_nxt = T_TLR;
    endcase
  end

  // Controller state register
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) tap_r <= T_TLR;
    else if (tck_rise) tap_r <= tap_nxt;
  end

  // Instruction shift stage
  dsp_scan_reg #(.W(IR_W)) u_ir (
    .clk     (mclk),
    .rst_n   (rst_n),
    .cap     (tck_rise && tap_r == T_CAPIR),
    .shf     (tck_rise && tap_r == T_SHIR),
    .cap_val (IR_CAPTURE),
    .sdi     (pin_s[0]),
    .q       (ir_q)
  );

  // Current instruction; exception forces bypass
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) ir_r <= IR_BYPASS;
    else if (dbg_exc) ir_r <= IR_BYPASS;
    else if (tck_rise && tap_r == T_TLR) ir_r <= IR_BYPASS;
    else if (tck_fall && tap_r == T_UPIR) ir_r <= ir_q;
  end

  // Instruction decode; unknown codes fall to bypass
  always_comb begin
    sel_byp = 1'b0;
    sel_id  = 1'b0;
    sel_imp = 1'b0;
    sel_adr = 1'b0;
    sel_dat = 1'b0;
    sel_ctl = 1'b0;
    if (ir_r == IR_IDCODE) sel_id = 1'b1;
    else if (ir_r == IR_IMPL) sel_imp = 1'b1;
    else if (ir_r == IR_ADDR) sel_adr = 1'b1;
    else if (ir_r == IR_DATA) sel_dat = 1'b1;
    else if (ir_r == IR_CTRL) sel_ctl = 1'b1;
    else sel_byp = 1'b1;
  end

  assign dr_cap = tck_rise && tap_r == T_CAPDR;
  assign dr_shf = tck_rise && tap_r == T_SHDR;
  assign dr_upd = tck_fall && tap_r == T_UPDR;

  // Parallel data registers; only the selected one moves
  dsp_scan_reg #(.W(1)) u_byp (
    .clk (mclk), .rst_n (rst_n), .cap (dr_cap && sel_byp),
    .shf (dr_shf && sel_byp), .cap_val (1'b0), .sdi (pin_s[0]),
    .q   (byp_q)
  );
  dsp_scan_reg #(.W(32)) u_id (
    .clk (mclk), .rst_n (rst_n), .cap (dr_cap && sel_id),
    .shf (dr_shf && sel_id), .cap_val (IDCODE_VAL), .sdi (pin_s[0]),
    .q   (id_q)
  );
  dsp_scan_reg #(.W(32)) u_imp (
    .clk (mclk), .rst_n (rst_n), .cap (dr_cap && sel_imp),
    .shf (dr_shf && sel_imp), .cap_val (IMPL_VAL), .sdi (pin_s[0]),
    .q   (imp_q)
  );
  dsp_scan_reg #(.W(32)) u_adr (
    .clk (mclk), .rst_n (rst_n), .cap (dr_cap && sel_adr),
    .shf (dr_shf && sel_adr), .cap_val (addr_hold_r), .sdi (pin_s[0]),
    .q   (adr_q)
  );
  dsp_scan_reg #(.W(32)) u_dat (
    .clk (mclk), .rst_n (rst_n), .cap (dr_cap && sel_dat),
    .shf (dr_shf && sel_dat), .cap_val (data_hold_r), .sdi (pin_s[0]),
    .q   (dat_q)
  );
  dsp_scan_reg #(.W(32)) u_ctl (
    .clk (mclk), .rst_n (rst_n), .cap (dr_cap && sel_ctl),
    .shf (dr_shf && sel_ctl), .cap_val (ctl_stat), .sdi (pin_s[0]),
    .q   (ctl_q)
  );

  // Status seen by the probe when it reads the control register
  always_comb begin
    ctl_stat             = '0;
    ctl_stat[CB_DM]      = proc_debug_mode;
    ctl_stat[CB_PEN]     = pen_r;
    ctl_stat[CB_DMA]     = dma_r;
    ctl_stat[CB_PACC]    = pend_r;
    ctl_stat[CB_DIR]     = dir_r;
    ctl_stat[CB_SZ+:2]   = size_r;
  end

  // Control writes come only from the scan path
  assign ctl_clear = dr_upd && sel_ctl && !ctl_q[CB_PACC];
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pen_r <= 1'b0;
      dma_r <= 1'b0;
    end else if (dr_upd && sel_ctl) begin
      pen_r <= ctl_q[CB_PEN];
      dma_r <= ctl_q[CB_DMA];
    end
  end

  // Access gate: window, probe enable and debug mode
  assign allowed = proc_pkt.addr >= WIN_LO && proc_pkt.addr <= WIN_HI &&
                   pen_r && proc_debug_mode;
  assign accept  = pst_r == PS_IDLE && !vec_r && proc_req && allowed;

  // Vector fetch request after a debug exception
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) vec_r <= 1'b0;
    else if (dbg_exc && pen_r) vec_r <= 1'b1;
    else if (pst_r == PS_IDLE) vec_r <= 1'b0;
  end

  // Pending flag; a new request wins over the probe's clear
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pend_r <= 1'b0;
    else if (accept || (pst_r == PS_IDLE && vec_r)) pend_r <= 1'b1;
    else if (ctl_clear) pend_r <= 1'b0;
  end

  // Latched address, direction and size of the access
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      addr_hold_r <= '0;
      dir_r       <= 1'b0;
      size_r      <= '0;
    end else if (pst_r == PS_IDLE && vec_r) begin
      addr_hold_r <= VEC_ADDR;
      dir_r       <= 1'b0;
      size_r      <= SIZE_WORD;
    end else if (accept) begin
      addr_hold_r <= proc_pkt.addr;
      dir_r       <= proc_pkt.we;
      size_r      <= proc_pkt.size;
    end
  end

  // Data holding: store data from core, read data from probe
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) data_hold_r <= '0;
    else if (accept && proc_pkt.we)
      data_hold_r <= lane_fix(proc_pkt.wdata, be_r);
    else if (dr_upd && sel_dat) data_hold_r <= dat_q;
  end

  // Access sequencer: wait for the probe, then hand back
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) pst_r <= PS_IDLE;
    else begin
      case (pst_r)
        PS_IDLE: if (accept || vec_r) pst_r <= PS_WAIT;
        PS_WAIT: if (!pend_r) pst_r <= PS_DONE;
        PS_DONE: pst_r <= PS_IDLE;
        default: pst_r <= PS_IDLE;
      endcase
    end
  end

  // Read word to the core once the probe has finished
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) proc_rdata <= '0;
    else if (pst_r == PS_WAIT && !pend_r)
      proc_rdata <= lane_fix(data_hold_r, be_r);
  end

  // Core handshake
  assign proc_done    = pst_r == PS_DONE;
  assign proc_stall   = proc_req && allowed && pst_r != PS_DONE;
  assign proc_refused = proc_req && !allowed && pst_r == PS_IDLE;

  // Trace mode: starts in idle under trace instruction
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) trace_r <= 1'b0;
    else if (dbg_exc || ir_r != IR_TRACE) trace_r <= 1'b0;
    else if (tap_r == T_RTI) trace_r <= 1'b1;
  end

  // Trace PC shifter and status bus
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      trace_sr_r <= '0;
      pcst_r     <= '0;
    end else begin
      pcst_r <= trace_r ? trace_type : 3'h0;
      if (trace_r && trace_pc_valid) trace_sr_r <= trace_pc;
      else if (trace_r && tck_fall) trace_sr_r <= {1'b0, trace_sr_r[31:1]};
    end
  end

  // Serial output bit of the selected path
  always_comb begin
    sel_q0 = byp_q;
    if (sel_id) sel_q0 = id_q[0];
    else if (sel_imp) sel_q0 = imp_q[0];
    else if (sel_adr) sel_q0 = adr_q[0];
    else if (sel_dat) sel_q0 = dat_q[0];
    else if (sel_ctl) sel_q0 = ctl_q[0];
  end

  // Output changes on the falling test clock edge
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_r      <= 1'b0;
      tdo_oe_n_r <= 1'b1;
    end else if (tck_fall) begin
      tdo_oe_n_r <= !(tap_r == T_SHDR || tap_r == T_SHIR || trace_r);
      if (trace_r) tdo_r <= trace_sr_r[0];
      else if (tap_r == T_SHIR) tdo_r <= ir_q[0];
      else if (tap_r == T_SHDR) tdo_r <= sel_q0;
    end
  end

  // APB configuration write
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) be_r <= CFG_BE_RST;
    else if (psel && penable && pwrite && paddr == ADDR_CFG)
      be_r <= pwdata[CFG_BE];
  end

  // APB read data prepared in the setup cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) prdata_r <= '0;
    else if (psel && !penable) begin
      prdata_r <= '0;
      if (paddr == ADDR_CFG) prdata_r[CFG_BE] <= be_r;
      else if (paddr == ADDR_STAT) begin
        prdata_r[ST_PACC]         <= pend_r;
        prdata_r[ST_DIR]          <= dir_r;
        prdata_r[ST_PEN]          <= pen_r;
        prdata_r[ST_TRACE]        <= trace_r;
        prdata_r[ST_IR+:IR_W]     <= ir_r;
      end
    end
  end

  assign prdata       = prdata_r;
  assign pready       = 1'b1;
  assign pslverr      = psel && penable &&
                        paddr != ADDR_CFG && paddr != ADDR_STAT;
  assign tdo          = tdo_r;
  assign tdo_oe_n     = tdo_oe_n_r;
  assign pcst         = pcst_r;
  assign trace_active = trace_r;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  a_bypass_zero: assert property (
    dr_cap && sel_byp |=> !byp_q) else $error("bypass not zero");
  a_unsel_hold: assert property (
    tck_rise && !sel_adr |=> $stable(adr_q)) else $error("addr moved");
  a_exc_bypass: assert property (
    dbg_exc |=> ir_r == IR_BYPASS && !trace_r) else $error("no bypass");
  a_gate_refuse: assert property (
    pst_r == PS_IDLE && !vec_r && proc_req && !allowed |=>
    pst_r == PS_IDLE) else $error("gated access ran");
  a_vector_fetch: assert property (
    dbg_exc && pen_r && pst_r == PS_IDLE |-> ##[1:2]
    (addr_hold_r == VEC_ADDR && pend_r && !dir_r))
    else $error("no vector fetch");
  a_read_latch: assert property (
    accept && !proc_pkt.we |=> pend_r && !dir_r &&
    addr_hold_r == $past(proc_pkt.addr)) else $error("read latch");
  a_store_latch: assert property (
    accept && proc_pkt.we |=> pend_r && dir_r &&
    data_hold_r == lane_fix($past(proc_pkt.wdata), be_r))
    else $error("store latch");
  a_done_seq: assert property (
    pst_r == PS_WAIT && !pend_r |=> proc_done ##1 pst_r == PS_IDLE)
    else $error("done sequence");
  a_stall_wait: assert property (
    pst_r == PS_WAIT && pend_r && proc_req && allowed |-> proc_stall)
    else $error("no stall");
  a_tdo_lsb: assert property (
    tck_fall && tap_r == T_SHDR && !trace_r |=> tdo == $past(sel_q0))
    else $error("tdo bit");
  a_trace_go: assert property (
    ir_r == IR_TRACE && tap_r == T_RTI && !dbg_exc |=> trace_active)
    else $error("trace not started");

endmodule : dsp_debug_scan

// File: dsp_probe.sv
// Probe model: drives the test pins and serves core memory accesses.
// Assumes the block samples the test clock; period is 320 ns.
`timescale 1ns/1ps
module dsp_probe (
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  import dsp_pkg::*;

  // Test clock stands low outside scans
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // One test clock; output taken late in the high phase, after it settles
  task automatic tick(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    #160 tck = 1'b1;
    #150 o = tdo;
    #10 tck = 1'b0;
  endtask : tick

  // Scan from idle back to idle; input is inverted once released
  task automatic sh(input logic ir, input int n, input logic [31:0] d,
                    output logic [31:0] q);
    logic o;
    q = '0;
    tick(1'b1, 1'b0, o);
    if (ir) tick(1'b1, 1'b0, o);
    tick(1'b0, 1'b0, o);
    tick(1'b0, 1'b0, o);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, d[i], o);
      q[i] = o;
    end
    tick(1'b1, 1'b0, o);
    tick(1'b0, ~d[n-1], o);
  endtask : sh

  // Load an instruction, then swap a full word through its register
  task automatic scan(input logic [4:0] c, input logic [31:0] d,
                      output logic [31:0] q);
    logic [31:0] x;
    sh(1'b1, 5, 32'(c), x);
    sh(1'b0, 32, d, q);
  endtask : scan

  // Poll, fetch address, swap data, then release the core
  task automatic serve(input logic [31:0] w, output logic [31:0] st, a, d);
    logic [31:0] x;
    st = '0;
    for (int i = 0; i < 40 && st[CB_PACC] !== 1'b1; i++)
      scan(IR_CTRL, 32'h0004_8000, st);
    scan(IR_ADDR, 32'h0, a);
    scan(IR_DATA, w, d);
    scan(IR_CTRL, 32'h0000_8000, x);
  endtask : serve
endmodule : dsp_probe

// File: dsp_debug_scan_tb.sv
// Testbench for the debug scan block: scans, register bus, core access.
// Assumes the probe model owns the test pins.
`timescale 1ns/1ps
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin \
  bad_count++; $display("BAD %s exp %h got %h", nm, e, g); end end
module dsp_debug_scan_tb;
  import dsp_pkg::*;
  logic         mclk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic         proc_req = 0, proc_debug_mode = 0, dbg_exc = 0, err, tpv = 0;
  logic         tck, tms, tdi, tdo, tdo_oe_n, pready, pslverr, tdo_line;
  logic         proc_stall, proc_done, proc_refused, trace_active;
  logic [11:0]  paddr = '0;
  logic [31:0]  pwdata = '0, prdata, proc_rdata, r, a, q, dw;
  logic [2:0]   pcst, ttype = 3'h5;
  dsp_preq_type proc_pkt = '0;
  int           bad_count = 0, num_checks = 0;

  // 25 MHz system clock
  always #20 mclk = ~mclk;

  dsp_debug_scan uut (.mclk, .reset_n, .tck, .tms, .tdi, .tdo, .tdo_oe_n,
    .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .proc_req, .proc_pkt, .proc_debug_mode, .proc_stall, .proc_done,
    .proc_refused, .proc_rdata, .dbg_exc, .trace_pc(32'h1234_5679),
    .trace_pc_valid(tpv), .trace_type(ttype), .pcst, .trace_active);
  dsp_probe p (.tck, .tms, .tdi, .tdo(tdo_line));

  // Released output reads inverted, so a wrong enable shows as bad data
  assign tdo_line = tdo_oe_n ? ~tdo : tdo;

  // Register bus transfer; data and error taken at the pready edge
  task automatic apb(input logic w, input logic [11:0] ad,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    paddr <= ad;
    pwrite <= w;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    r = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Core request or debug exception, served by the probe
  task automatic acc(input logic ex, we, input logic [31:0] ad, w);
    logic [31:0] st;
    @(posedge mclk);
    if (ex) dbg_exc <= 1'b1;
    else begin
      proc_req <= 1'b1;
      proc_pkt <= '{we, SIZE_WORD, ad, w};
    end
    @(posedge mclk);
    dbg_exc <= 1'b0;
    repeat (4) @(posedge mclk);
    `CHK("stall", !ex, proc_stall)
    if (ex) begin
      apb(1'b0, ADDR_STAT, '0);
      `CHK("ir", IR_BYPASS, r[ST_IR+:5])
      `CHK("trace_st", 1'b0, r[ST_TRACE])
    end
    fork
      p.serve(w, st, a, dw);
      begin
        do @(posedge mclk); while (proc_done !== 1'b1);
        r = proc_rdata;
        proc_req <= 1'b0;
      end
    join
    `CHK("addr", ad, a)
    `CHK("pend", 1'b1, st[CB_PACC])
    `CHK("dir", we, st[CB_DIR])
    `CHK("size", SIZE_WORD, st[CB_SZ+:2])
  endtask : acc

  // Control register and bus map
  task automatic t_regs;
    proc_debug_mode <= 1'b1;
    apb(1'b0, ADDR_CFG, '0);
    `CHK("cfg_rst", 32'h0, r)
    p.scan(IR_CTRL, 32'h0004_8000, q);
    `CHK("ctl_dm", 1'b1, q[CB_DM])
    `CHK("ctl_pend", 1'b0, q[CB_PACC])
    apb(1'b1, ADDR_STAT, '0);
    apb(1'b0, ADDR_STAT, '0);
    `CHK("pen", 1'b1, r[ST_PEN])
    apb(1'b0, 12'h010, '0);
    `CHK("slverr", 1'b1, err)
  endtask : t_regs

  // Fixed registers and the bypass stage, including an unused code
  task automatic t_dr;
    logic [4:0]  c [4] = '{IR_IDCODE, IR_IMPL, IR_BYPASS, 5'h1E};
    logic [31:0] e [4] = '{IDCODE_DEF, IMPL_DEF, 32'hFFFF_FFFE,
                           32'hFFFF_FFFE};
    for (int i = 0; i < 4; i++) begin
      p.scan(c[i], 32'hFFFF_FFFF, q);
      `CHK("dr", e[i], q)
    end
  endtask : t_dr

  // Requests outside debug mode or the window do nothing
  task automatic t_refuse;
    proc_debug_mode <= 1'b0;
    repeat (4) @(posedge mclk);
    proc_req <= 1'b1;
    proc_pkt <= '{1'b0, SIZE_WORD, WIN_LO, 32'h0};
    repeat (2) @(posedge mclk);
    `CHK("ref_dm", 1'b1, proc_refused)
    proc_debug_mode <= 1'b1;
    proc_pkt.addr <= WIN_HI + 32'h1;
    repeat (2) @(posedge mclk);
    `CHK("ref_win", 1'b1, proc_refused)
    `CHK("ref_stall", 1'b0, proc_stall)
    proc_req <= 1'b0;
  endtask : t_refuse

  // Trace, then a debug exception that fetches from the vector
  task automatic t_trace;
    p.sh(1'b1, 5, 32'(IR_TRACE), q);
    repeat (10) @(posedge mclk);
    `CHK("trace", 1'b1, trace_active)
    `CHK("pcst", ttype, pcst)
    // Load one PC word; first sample is stale, then one bit per test clock
    tpv <= 1'b1;
    @(posedge mclk);
    tpv <= 1'b0;
    for (int i = 0; i < 9; i++)
      p.tick(1'b0, 1'b0, q[i]);
    `CHK("trace_pc", 8'h79, q[8:1])
    acc(1'b1, 1'b0, VEC_ADDR, 32'h0102_0304);
    `CHK("vec", 32'h0102_0304, r)
    `CHK("trace_off", 1'b0, trace_active)
  endtask : t_trace

  // Next fetch, big-endian store at the window bottom and load at the window top
  task automatic t_rw;
    acc(1'b0, 1'b0, VEC_ADDR + 32'h4, 32'hA5C3_1234);
    `CHK("rd", 32'hA5C3_1234, r)
    apb(1'b1, ADDR_CFG, 32'h1);
    acc(1'b0, 1'b1, WIN_LO, 32'h1122_3344);
    `CHK("wr", 32'h4433_2211, dw)
    acc(1'b0, 1'b0, 32'hFF2F_FFFC, 32'h0102_0304);
    `CHK("ld", 32'h0403_0201, r)
    apb(1'b0, ADDR_STAT, '0);
    `CHK("idle", 1'b0, r[ST_PACC])
  endtask : t_rw

  task automatic end_of_test;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : end_of_test

  // Main sequence
  initial begin
    repeat (10) @(posedge mclk);
    reset_n <= 1'b1;
    repeat (3) @(posedge mclk);
    p.tick(1'b0, 1'b0, q[0]);
    t_regs;
    t_dr;
    t_refuse;
    t_trace;
    t_rw;
    end_of_test;
  end

  // Watchdog, well beyond the expected run
  initial begin
    #2000000;
    bad_count++;
    end_of_test;
  end
endmodule : dsp_debug_scan_tb
